// *** hw/mpps_pkg.sv ***
package mpps_pkg;

  localparam int NUM_CH = 4;
  // Switching period in cycles of clock_in until the first wrap; then set by the frequency resistor outside
  localparam logic [15:0] PERIOD_RST = 16'h0190;
  localparam logic [15:0] PERIOD_MIN = 16'h000c;
  localparam logic [1:0] MODE_FOUR = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h1;
  localparam logic [1:0] MODE_THREE = 2'h2;

  typedef struct packed {
    logic [NUM_CH-1:0] drive;
    logic [NUM_CH-1:0] sample;
    logic [NUM_CH-1:0] hold;
  } mpps_chan_t;

endpackage : mpps_pkg

// *** hw/mpps_sequencer.sv ***
// Overview of operation
// R01 - Active phases end their pulses at equal fractions of the cycle.
// R02 - Without any strap all four phases run.
// R03 - A cycle runs between successive termination events of phase one.
// R04 - Termination clock period equals the programmed switching period.
// R05 - Four-phase mode ends phases two to four a quarter cycle apart.
// R06 - Phase three strapped high selects two phases, half cycle apart.
// R07 - Phase four strapped high selects three phases, third cycle apart.
// R08 - Each output stays low for at least a third of the cycle.
// R09 - Output is re-enabled only after the forced off-time has elapsed.
// R10 - An enabled output rises when its ramp comparator says so.
// R11 - A high output stays high until its termination event.
// R12 - Driver turns upper switch off and lower on when output falls.
// R13 - Driver turns lower switch off and upper on when output rises.
// R14 - Channels excluded by the straps stay fully inactive.
// R15 - Current is captured only after settling, then held.
// R16 - Sample starts at falling edge, lasts a third cycle, holds a cycle; hold here ends at the next termination, about two thirds of a cycle.
// R17 - Ramp-crossing decisions arrive as synchronous single-bit inputs.
// R18 - Reset holds outputs low; straps are resampled on reset release.
`timescale 1ns/1ps
module mpps_sequencer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [15:0] freq_select_resistor_in,
  input wire logic [3:0] ramp_cross_in,
  input wire logic phase3_strap_in,
  input wire logic phase4_strap_in,
  output logic phase1_drive_out,
  output logic phase2_drive_out,
  output logic phase3_drive_out,
  output logic phase4_drive_out,
  output logic phase3_drive_oe_out,
  output logic phase4_drive_oe_out,
  output logic [3:0] channel_current_sense_sample_out,
  output logic [3:0] channel_current_sense_hold_out,
  output logic [3:0] channel_active_out,
  output logic [1:0] phase_mode_out
);

  localparam int N = mpps_pkg::NUM_CH;

  // Termination offset of channel idx in cycles for the given mode
  function automatic logic [15:0] term_offset(input logic [1:0] mode, input logic [15:0] per,
                                              input int idx);
    logic [17:0] prod;
    prod = 18'h0;
    case (mode)
      mpps_pkg::MODE_TWO: prod = 18'(per) * 18'(idx) / 18'h2;
      mpps_pkg::MODE_THREE: prod = 18'(per) * 18'(idx) / 18'h3;
      default: prod = 18'(per) * 18'(idx) / 18'h4;
    endcase
    return prod[15:0];
  endfunction : term_offset

  function automatic logic [3:0] active_mask(input logic [1:0] mode);
    case (mode)
      mpps_pkg::MODE_TWO: return 4'h3;
      mpps_pkg::MODE_THREE: return 4'h7;
      default: return 4'hf;
    endcase
  endfunction : active_mask

  // Periods shorter than the floor would squeeze the off-time to nothing
  function automatic logic [15:0] clamp_period(input logic [15:0] raw);
    if (raw >= mpps_pkg::PERIOD_MIN)
      return raw;
    else
      return mpps_pkg::PERIOD_MIN;
  endfunction : clamp_period

  typedef enum logic [1:0] {ST_RESET, ST_STRAP, ST_RUN} mpps_state_t;

  mpps_state_t state_r;
  logic [1:0] mode_r;
  logic [15:0] period_r;
  logic [15:0] cnt_r;
  logic [15:0] off_min;
  logic wrap;
  logic run;
  logic [N-1:0] drive_r;
  logic [N-1:0] enabled_r;
  logic [N-1:0] term;
  logic [N-1:0] off_done;
  logic [N-1:0] win_end;
  logic [15:0] off_cnt_r [N];
  logic [15:0] offs_r [N];
  logic [N-1:0] samp_r;
  logic [N-1:0] hold_r;
  logic [3:0] act_r;
  logic strap_oe_r;

  // Forced off-time and sample window, a third of the period
  assign off_min = period_r / 16'h3;
  assign wrap = (cnt_r >= period_r - 16'h1);
  assign run = (state_r == ST_RUN);

  // Reset, strap read, run
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      state_r <= ST_RESET;
    else
    begin
      case (state_r)
        ST_RESET: state_r <= ST_STRAP; // R18
        ST_STRAP: state_r <= ST_RUN;
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_RESET;
      endcase
    end
  end

  // Straps read once, while the phase 3/4 pins are still released
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      mode_r <= mpps_pkg::MODE_FOUR;
    else if (state_r == ST_STRAP)
    begin
      if (phase3_strap_in)
        mode_r <= mpps_pkg::MODE_TWO; // R06
      else if (phase4_strap_in)
        mode_r <= mpps_pkg::MODE_THREE; // R07
      else
        mode_r <= mpps_pkg::MODE_FOUR; // R02
    end
  end

  // Pins may be driven only after the strap read
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      strap_oe_r <= 1'b0;
    else if (state_r == ST_STRAP)
      strap_oe_r <= 1'b1;
  end

  // Termination clock
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || !run)
      cnt_r <= 16'h0;
    else if (wrap)
      cnt_r <= 16'h0; // R03
    else
      cnt_r <= cnt_r + 16'h1;
  end

  // New period taken only at the wrap, so no cycle is cut short
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || !run)
      period_r <= mpps_pkg::PERIOD_RST;
    else if (wrap)
      period_r <= clamp_period(freq_select_resistor_in); // R04
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      act_r <= 4'h0;
    else if (run)
      act_r <= active_mask(mode_r); // R14
    else
      act_r <= 4'h0;
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      // Offset registered to keep the divider off the compare path
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in)
          offs_r[g] <= 16'h0;
        else
          offs_r[g] <= term_offset(mode_r, period_r, g); // R01 R05 R06 R07
      end

      assign term[g] = run && act_r[g] && (cnt_r == offs_r[g]); // R01 R05 R06 R07
      assign off_done[g] = (off_cnt_r[g] + 16'h1 >= off_min);
      assign win_end[g] = samp_r[g] && off_done[g];

      // Forced off-time counter, restarted at each termination
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in || !act_r[g])
          off_cnt_r[g] <= 16'h0;
        else if (term[g])
          off_cnt_r[g] <= 16'h0;
        else if (!enabled_r[g])
          off_cnt_r[g] <= off_cnt_r[g] + 16'h1;
      end

      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in || !act_r[g])
          enabled_r[g] <= 1'b0;
        else if (term[g])
          enabled_r[g] <= 1'b0;
        else if (!enabled_r[g] && off_done[g])
          enabled_r[g] <= 1'b1; // R08 R09
      end

      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in || !act_r[g])
          drive_r[g] <= 1'b0; // R18 R14
        else if (term[g])
          drive_r[g] <= 1'b0; // R11
        else if (enabled_r[g] && ramp_cross_in[g] && !drive_r[g])
          drive_r[g] <= 1'b1; // R10 R17
      end

      // Sample window of a third cycle from the falling edge
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in || !act_r[g])
          samp_r[g] <= 1'b0;
        else if (term[g])
          samp_r[g] <= 1'b1; // R16
        else if (win_end[g])
          samp_r[g] <= 1'b0;
      end

      // Held value stands until the next termination
      always_ff @(posedge clock_in)
      begin
        if (!rst_n_in || !act_r[g])
          hold_r[g] <= 1'b0;
        else if (term[g])
          hold_r[g] <= 1'b0;
        else if (win_end[g])
          hold_r[g] <= 1'b1; // R15
      end
    end
  endgenerate

  // Phase drives, one register stage to the pins
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      phase1_drive_out <= 1'b0;
      phase2_drive_out <= 1'b0;
      phase3_drive_out <= 1'b0;
      phase4_drive_out <= 1'b0;
    end
    else
    begin
      phase1_drive_out <= drive_r[0];
      phase2_drive_out <= drive_r[1];
      phase3_drive_out <= drive_r[2];
      phase4_drive_out <= drive_r[3];
    end
  end

  // Strapped pins are never driven
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      phase3_drive_oe_out <= 1'b0;
      phase4_drive_oe_out <= 1'b0;
    end
    else
    begin
      phase3_drive_oe_out <= strap_oe_r && act_r[2];
      phase4_drive_oe_out <= strap_oe_r && act_r[3];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      channel_current_sense_sample_out <= 4'h0;
      channel_current_sense_hold_out <= 4'h0;
    end
    else
    begin
      channel_current_sense_sample_out <= samp_r;
      channel_current_sense_hold_out <= hold_r;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      channel_active_out <= 4'h0;
      phase_mode_out <= mpps_pkg::MODE_FOUR;
    end
    else
    begin
      channel_active_out <= act_r;
      phase_mode_out <= mode_r;
    end
  end

endmodule : mpps_sequencer

// *** tb/mpps_asserts.sv ***
`timescale 1ns/1ps
module mpps_asserts (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] ramp_cross_in,
  input wire logic phase1_drive_out,
  input wire logic phase4_drive_out,
  input wire logic [3:0] channel_current_sense_sample_out,
  input wire logic [3:0] channel_current_sense_hold_out,
  input wire logic [3:0] channel_active_out,
  input wire logic [1:0] phase_mode_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_fall;
    $fell(phase1_drive_out);
  endsequence
  sequence s_win;
    $rose(channel_current_sense_sample_out[0]);
  endsequence
  a_off_time: assert property (s_fall |=> !phase1_drive_out [*3])
    else $error("off time short");
  a_rst_low: assert property (disable iff (1'b0) !rst_n_in |=>
    !phase1_drive_out && channel_active_out == 4'h0) else $error("reset output");
  a_mode_mask: assert property (channel_active_out != 4'h0 |-> channel_active_out ==
    (phase_mode_out == 2'h1 ? 4'h3 : phase_mode_out == 2'h2 ? 4'h7 : 4'hf))
    else $error("mask vs mode");
  a_unused_quiet: assert property (!channel_active_out[3] |-> !phase4_drive_out &&
    !channel_current_sense_sample_out[3] && !channel_current_sense_hold_out[3])
    else $error("unused active");
  a_win_len: assert property (s_win |-> channel_current_sense_sample_out[0] [*4])
    else $error("window short");
  a_hold_after: assert property ($fell(channel_current_sense_sample_out[0]) |->
    channel_current_sense_hold_out[0]) else $error("no hold");
  a_no_rise_win: assert property ($rose(phase1_drive_out) |->
    !channel_current_sense_sample_out[0]) else $error("rise in window");
  a_rise_cause: assert property ($rose(phase1_drive_out) |-> $past(ramp_cross_in[0], 2))
    else $error("rise uncaused");
  a_mode_stable: assert property (channel_active_out[0] |=> $stable(phase_mode_out))
    else $error("mode moved");
endmodule : mpps_asserts
bind mpps_sequencer mpps_asserts u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .ramp_cross_in(ramp_cross_in), .phase1_drive_out(phase1_drive_out),
  .phase4_drive_out(phase4_drive_out), .channel_active_out(channel_active_out),
  .channel_current_sense_sample_out(channel_current_sense_sample_out),
  .channel_current_sense_hold_out(channel_current_sense_hold_out),
  .phase_mode_out(phase_mode_out));

// *** tb/mpps_driver_model.sv ***
`timescale 1ns/1ps
module mpps_driver_model (
  input wire logic [3:0] pwm_in,
  output logic [3:0] upper_on_out,
  output logic [3:0] lower_on_out
);
  assign upper_on_out = pwm_in;
  assign lower_on_out = ~pwm_in;
endmodule : mpps_driver_model

// *** tb/multiphase_pwm_sequencer_bench.sv ***
`timescale 1ns/1ps
module multiphase_pwm_sequencer_bench;
  localparam int P = 24;
  logic clock_in = 0, rst_n_in = 0, s3 = 0, s4 = 0;
  logic [3:0] ramp = 4'h0, drv, drv_q = 4'h0, act, smp, hld, up, dn;
  logic oe3, oe4;
  logic [1:0] mode;
  int cyc, n_fail, checks, tf[4], per[4], lo[4];
  initial forever #5 clock_in = ~clock_in;
  mpps_sequencer dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .freq_select_resistor_in(16'h0018), .ramp_cross_in(ramp), .phase3_strap_in(s3),
    .phase4_strap_in(s4), .phase1_drive_out(drv[0]), .phase2_drive_out(drv[1]),
    .phase3_drive_out(drv[2]), .phase4_drive_out(drv[3]), .phase3_drive_oe_out(oe3),
    .phase4_drive_oe_out(oe4), .channel_current_sense_sample_out(smp),
    .channel_current_sense_hold_out(hld), .channel_active_out(act), .phase_mode_out(mode));
  mpps_driver_model drv_u (.pwm_in(drv), .upper_on_out(up), .lower_on_out(dn));
  always @(posedge clock_in)
  begin
    cyc++;
    for (int k = 0; k < 4; k++)
    begin
      if (drv_q[k] && !drv[k])
      begin
        per[k] = cyc - tf[k];
        tf[k] = cyc;
      end
      if (!drv_q[k] && drv[k]) lo[k] = cyc - tf[k];
    end
    drv_q = drv;
  end
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task close_out;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task run_mode(logic a, logic b, logic [1:0] me, logic [3:0] ke, int m);
    @(posedge clock_in) #1 rst_n_in = 0;
    {s3, s4, ramp} = {a, b, 4'hf};
    repeat (5) @(posedge clock_in);
    #1 chk("rst", {act, drv}, 8'h00);
    rst_n_in = 1;
    for (int k = 0; k < 4; k++) {tf[k], per[k], lo[k]} = 96'h0;
    // First cycle still runs at the reset period
    repeat (mpps_pkg::PERIOD_RST + 4 * P) @(posedge clock_in);
    #1 chk("mode", {act, mode}, {ke, me});
    chk("oe", {oe4, oe3}, ke[3:2]);
    chk("period", per[0], P);
    for (int k = 0; k < 4; k++)
      if (ke[k])
      begin
        chk("stagger", (tf[k] - tf[0] + P) % P, k * P / m);
        chk("off", lo[k] >= P / 3, 1);
      end
      else chk("idle", lo[k] + tf[k], 0);
  endtask : run_mode
  task ramp_test;
    ramp = 4'h0;
    repeat (2 * P) @(posedge clock_in);
    chk("no cross", drv, 4'h0);
    for (int i = 0; i < P && !smp[0]; i++) @(posedge clock_in);
    for (int i = 0; i < P && !(hld[0] && !smp[0]); i++) @(posedge clock_in);
    #1 ramp = 4'h1;
    @(posedge clock_in) #1 ramp = 4'h0;
    repeat (5) @(posedge clock_in);
    chk("rise", {drv[0], up[0], dn[0]}, 3'h6);
    for (int i = 0; i < P && drv[0]; i++) @(posedge clock_in);
    #1 chk("fall", per[0] % P, 0);
    chk("drive off", {up[0], dn[0]}, 2'h1);
  endtask : ramp_test
  initial
  begin
    run_mode(0, 1, 2'h2, 4'h7, 3);
    run_mode(1, 0, 2'h1, 4'h3, 2);
    run_mode(0, 0, 2'h0, 4'hf, 4);
    ramp_test;
    close_out;
  end
  initial
  begin
    #100000;
    n_fail++;
    close_out;
  end
endmodule : multiphase_pwm_sequencer_bench
